/* core/asp_pkg.sv */
// Purpose: Constants and types of the audio port pins.
// Assumes: APB byte addresses, 32-bit data, one register per aligned word.
// Notes: Shared by core and bench.
package asp_pkg;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 8;
    localparam int NPIN = 5;
    localparam int NCH = 3;
    // Pin indices: clock pins first, then the three shared data pins.
    localparam int P_RCK = 0;
    localparam int P_TCK = 1;
    localparam int P_DAT = 2;
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_RCCR = 8'h04;
    localparam logic [ADDR_W-1:0] A_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] A_GPO = 8'h0C;
    localparam logic [ADDR_W-1:0] A_GPI = 8'h10;
    localparam logic [ADDR_W-1:0] A_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] A_TX0 = 8'h18;
    localparam logic [ADDR_W-1:0] A_RX0 = 8'h24;
    localparam logic [ADDR_W-1:0] A_STEP = 8'h04;
    // Field positions in serial_audio_control_reg.
    localparam int B_SYNC = 0;
    localparam int B_NET = 1;
    localparam int B_OF0 = 2;
    localparam int B_DIR = 3;
    localparam int B_EN = 6;
    // Field positions in receive_clock_control_reg and the status register.
    localparam int B_RX_CLOCK_DIRECTION_BIT = 0;
    localparam int B_TCKD = 1;
    localparam int B_IF0 = 0;
    // Per-pin function codes in the pin mode register, two bits per pin.
    localparam logic [1:0] M_OFF = 2'h0;
    localparam logic [1:0] M_IN = 2'h1;
    localparam logic [1:0] M_OUT = 2'h2;
    localparam logic [1:0] M_FUNC = 2'h3;

    typedef struct packed {
        logic sync_mode_select;
        logic net_mode;
        logic output_flag_zero;
        logic [NCH-1:0] ch_is_tx;
        logic [NCH-1:0] ch_en;
        logic rx_clock_direction_bit;
        logic tx_clock_direction_bit;
        logic [2*NPIN-1:0] pin_mode;
        logic [NPIN-1:0] gpio_out;
    } asp_cfg_t;

    localparam asp_cfg_t CFG_RST = '0;
endpackage

/* core/asp_pin_port.sv */
// Purpose: Pin functions of the second audio serial port behind APB.
// Assumes: link_clk runs free; bit clocks are far slower than link_clk.
// Notes: One packed state struct per clock domain, pclk and link_clk.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module asp_pin_port #(
    parameter int WORD_W = 24,
    parameter int SLOTS = 2,
    parameter int CLK_DIV = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [asp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic rx_bit_clock_pin_i,
    output logic rx_bit_clock_pin_o,
    output logic rx_bit_clock_pin_oe,
    input wire logic tx_bit_clock_pin_i,
    output logic tx_bit_clock_pin_o,
    output logic tx_bit_clock_pin_oe,
    input wire logic [asp_pkg::NCH-1:0] data_pin_i,
    output logic [asp_pkg::NCH-1:0] data_pin_o,
    output logic [asp_pkg::NCH-1:0] data_pin_oe
);
    localparam int NP = asp_pkg::NPIN;
    localparam int NC = asp_pkg::NCH;
    localparam int CW = asp_pkg::CNT_W;
    localparam logic [CW-1:0] BIT_LAST = CW'(WORD_W - 1);
    localparam logic [CW-1:0] SLOT_LAST = CW'(SLOTS - 1);
    localparam logic [CW-1:0] DIV_LAST = CW'(CLK_DIV - 1);
    localparam logic [CW-1:0] ONE = 8'h01;

    typedef logic [NC-1:0][WORD_W-1:0] asp_words_t;

    typedef struct packed {
        asp_pkg::asp_cfg_t cfg;
        asp_words_t tx_word;
        asp_words_t rx_word;
        logic tx_tgl;
        logic rxt_s1;
        logic rxt_s2;
        logic rxt_s3;
        logic ifl_s1;
        logic ifl_s2;
        logic [NP-1:0] gpi_s1;
        logic [NP-1:0] gpi_s2;
        logic [NP-1:0] gpi_s3;
        logic [NP-1:0] gpi_v;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } asp_bus_t;

    typedef struct packed {
        asp_pkg::asp_cfg_t cfg_s1;
        asp_pkg::asp_cfg_t cfg_s2;
        logic [NP-1:0] pin_s1;
        logic [NP-1:0] pin_s2;
        logic [NP-1:0] pin_s3;
        logic [NP-1:0] pin_v;
        logic txt_s1;
        logic txt_s2;
        logic txt_s3;
        logic [CW-1:0] div_cnt;
        logic gen_clk;
        logic tck_d;
        logic rck_d;
        logic [CW-1:0] tbit;
        logic [CW-1:0] tslot;
        logic [CW-1:0] rbit;
        asp_words_t tx_hold;
        asp_words_t tx_sh;
        asp_words_t rx_sh;
        asp_words_t rx_hold;
        logic rx_tgl;
        logic of0_q;
        logic if0_q;
        logic [NP-1:0] pin_o;
        logic [NP-1:0] pin_oe;
    } asp_link_t;

    asp_bus_t bus_ff;
    asp_bus_t nxt_bus;
    asp_link_t lnk_ff;
    asp_link_t nxt_lnk;
    logic [NP-1:0] pin_in;

    // All five pins in pin index order.
    assign pin_in = {data_pin_i, tx_bit_clock_pin_i, rx_bit_clock_pin_i};

    // Bus domain: APB slave, registers, link crossings.
    always_comb
    begin
        logic acc;
        logic [31:0] rd;
        logic err;
        logic [1:0] md;
        acc = psel & penable & bus_ff.pready;
        rd = '0;
        err = 1'b0;
        md = asp_pkg::M_OFF;
        nxt_bus = bus_ff;
        // Pins pass three flops; a change counts once two agree.
        nxt_bus.gpi_s1 = pin_in;
        nxt_bus.gpi_s2 = bus_ff.gpi_s1;
        nxt_bus.gpi_s3 = bus_ff.gpi_s2;
        for (int i = 0; i < NP; i++)
        begin
            if (bus_ff.gpi_s2[i] == bus_ff.gpi_s3[i])
            begin
                nxt_bus.gpi_v[i] = bus_ff.gpi_s2[i];
            end
        end
        // Received words cross by toggle.
        nxt_bus.rxt_s1 = lnk_ff.rx_tgl;
        nxt_bus.rxt_s2 = bus_ff.rxt_s1;
        nxt_bus.rxt_s3 = bus_ff.rxt_s2;
        if (bus_ff.rxt_s2 != bus_ff.rxt_s3)
        begin
            nxt_bus.rx_word = lnk_ff.rx_hold;
        end
        nxt_bus.ifl_s1 = lnk_ff.if0_q;
        nxt_bus.ifl_s2 = bus_ff.ifl_s1;
        // Read data and error load in setup.
        case (paddr)
            asp_pkg::A_CTRL:
            begin
                rd[asp_pkg::B_SYNC] = bus_ff.cfg.sync_mode_select;
                rd[asp_pkg::B_NET] = bus_ff.cfg.net_mode;
                rd[asp_pkg::B_OF0] = bus_ff.cfg.output_flag_zero;
                rd[asp_pkg::B_DIR+:NC] = bus_ff.cfg.ch_is_tx;
                rd[asp_pkg::B_EN+:NC] = bus_ff.cfg.ch_en;
            end
            asp_pkg::A_RCCR:
            begin
                rd[asp_pkg::B_RX_CLOCK_DIRECTION_BIT] = bus_ff.cfg.rx_clock_direction_bit;
                rd[asp_pkg::B_TCKD] = bus_ff.cfg.tx_clock_direction_bit;
            end
            asp_pkg::A_MODE: rd[2*NP-1:0] = bus_ff.cfg.pin_mode;
            asp_pkg::A_GPO: rd[NP-1:0] = bus_ff.cfg.gpio_out;
            asp_pkg::A_GPI:
            begin
                for (int i = 0; i < NP; i++)
                begin
                    md = bus_ff.cfg.pin_mode[2*i+:2];
                    rd[i] = (md == asp_pkg::M_IN) & bus_ff.gpi_v[i];
                end
            end
            asp_pkg::A_STAT: rd[asp_pkg::B_IF0] = bus_ff.ifl_s2;
            default:
            begin
                err = 1'b1;
                for (int k = 0; k < NC; k++)
                begin
                    if (paddr == asp_pkg::A_TX0 + asp_pkg::A_STEP * k[7:0])
                    begin
                        rd[WORD_W-1:0] = bus_ff.tx_word[k];
                        err = 1'b0;
                    end
                    if (paddr == asp_pkg::A_RX0 + asp_pkg::A_STEP * k[7:0])
                    begin
                        rd[WORD_W-1:0] = bus_ff.rx_word[k];
                        err = 1'b0;
                    end
                end
            end
        endcase
        nxt_bus.pready = psel & ~penable;
        if (psel & ~penable)
        begin
            nxt_bus.prdata = rd;
            nxt_bus.pslverr = err;
        end
        // Writes land at the access edge.
        if (acc & pwrite & ~bus_ff.pslverr)
        begin
            case (paddr)
                asp_pkg::A_CTRL:
                begin
                    nxt_bus.cfg.sync_mode_select = pwdata[asp_pkg::B_SYNC];
                    nxt_bus.cfg.net_mode = pwdata[asp_pkg::B_NET];
                    nxt_bus.cfg.output_flag_zero = pwdata[asp_pkg::B_OF0];
                    nxt_bus.cfg.ch_is_tx = pwdata[asp_pkg::B_DIR+:NC];
                    nxt_bus.cfg.ch_en = pwdata[asp_pkg::B_EN+:NC];
                end
                asp_pkg::A_RCCR:
                begin
                    nxt_bus.cfg.rx_clock_direction_bit =
                        pwdata[asp_pkg::B_RX_CLOCK_DIRECTION_BIT];
                    nxt_bus.cfg.tx_clock_direction_bit =
                        pwdata[asp_pkg::B_TCKD];
                end
                asp_pkg::A_MODE: nxt_bus.cfg.pin_mode = pwdata[2*NP-1:0];
                asp_pkg::A_GPO: nxt_bus.cfg.gpio_out = pwdata[NP-1:0];
                default:
                begin
                    for (int k = 0; k < NC; k++)
                    begin
                        if (paddr == asp_pkg::A_TX0 + asp_pkg::A_STEP * k[7:0])
                        begin
                            nxt_bus.tx_word[k] = pwdata[WORD_W-1:0];
                            nxt_bus.tx_tgl = ~bus_ff.tx_tgl;
                        end
                    end
                end
            endcase
        end
    end

    // reset puts every pin in disconnected GPIO mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_ff <= '{cfg: asp_pkg::CFG_RST, default: '0};
        end
        else
        begin
            bus_ff <= nxt_bus;
        end
    end

    // Link domain: bit clocks, shifting, flag zero and pin drivers.
    always_comb
    begin
        asp_pkg::asp_cfg_t cf;
        logic [NP-1:0] fn;
        logic [NP-1:0] f_o;
        logic [NP-1:0] f_oe;
        logic gen_rise;
        logic tck_rise;
        logic rck_rise;
        logic rx_rise;
        logic t_last;
        logic r_last;
        logic flag_evt;
        logic [1:0] md;
        cf = lnk_ff.cfg_s2;
        fn = '0;
        f_o = '0;
        f_oe = '0;
        md = asp_pkg::M_OFF;
        nxt_lnk = lnk_ff;
        nxt_lnk.cfg_s1 = bus_ff.cfg;
        nxt_lnk.cfg_s2 = lnk_ff.cfg_s1;
        nxt_lnk.pin_s1 = pin_in;
        nxt_lnk.pin_s2 = lnk_ff.pin_s1;
        nxt_lnk.pin_s3 = lnk_ff.pin_s2;
        for (int i = 0; i < NP; i++)
        begin
            if (lnk_ff.pin_s2[i] == lnk_ff.pin_s3[i])
            begin
                nxt_lnk.pin_v[i] = lnk_ff.pin_s2[i];
            end
            fn[i] = cf.pin_mode[2*i+:2] == asp_pkg::M_FUNC;
        end
        // Transmit words cross by toggle.
        nxt_lnk.txt_s1 = bus_ff.tx_tgl;
        nxt_lnk.txt_s2 = lnk_ff.txt_s1;
        nxt_lnk.txt_s3 = lnk_ff.txt_s2;
        if (lnk_ff.txt_s2 != lnk_ff.txt_s3)
        begin
            nxt_lnk.tx_hold = bus_ff.tx_word;
        end
        // Internal bit clock for output clock pins.
        gen_rise = (lnk_ff.div_cnt == DIV_LAST) & ~lnk_ff.gen_clk;
        if (lnk_ff.div_cnt == DIV_LAST)
        begin
            nxt_lnk.div_cnt = '0;
            nxt_lnk.gen_clk = ~lnk_ff.gen_clk;
        end
        else
        begin
            nxt_lnk.div_cnt = lnk_ff.div_cnt + ONE;
        end
        nxt_lnk.tck_d = lnk_ff.pin_v[asp_pkg::P_TCK];
        nxt_lnk.rck_d = lnk_ff.pin_v[asp_pkg::P_RCK];
        // transmitters run from the transmit clock pin's edges, or from the divider when that pin is an output
        tck_rise = cf.tx_clock_direction_bit ? gen_rise :
            lnk_ff.pin_v[asp_pkg::P_TCK] & ~lnk_ff.tck_d;
        tck_rise = tck_rise & fn[asp_pkg::P_TCK];
        rck_rise = cf.rx_clock_direction_bit ? gen_rise :
            lnk_ff.pin_v[asp_pkg::P_RCK] & ~lnk_ff.rck_d;
        rck_rise = rck_rise & fn[asp_pkg::P_RCK];
        // receivers follow the mode's clock pin
        rx_rise = cf.sync_mode_select ? tck_rise : rck_rise;
        // Transmit slot and frame counting; receive bit counting.
        t_last = lnk_ff.tbit == BIT_LAST;
        if (tck_rise)
        begin
            nxt_lnk.tbit = t_last ? '0 : lnk_ff.tbit + ONE;
            if (t_last)
            begin
                nxt_lnk.tslot = (lnk_ff.tslot == SLOT_LAST) ? '0 :
                    lnk_ff.tslot + ONE;
            end
        end
        r_last = lnk_ff.rbit == BIT_LAST;
        if (rx_rise)
        begin
            nxt_lnk.rbit = r_last ? '0 : lnk_ff.rbit + ONE;
        end
        // one shared data pin per channel, used to transmit or to receive
        for (int k = 0; k < NC; k++)
        begin
            if (tck_rise & cf.ch_en[k] & cf.ch_is_tx[k])
            begin
                nxt_lnk.tx_sh[k] = t_last ? lnk_ff.tx_hold[k] :
                    {lnk_ff.tx_sh[k][WORD_W-2:0], 1'b0};
            end
            if (rx_rise & cf.ch_en[k] & ~cf.ch_is_tx[k] & fn[asp_pkg::P_DAT+k])
            begin
                nxt_lnk.rx_sh[k] = {lnk_ff.rx_sh[k][WORD_W-2:0],
                    lnk_ff.pin_v[asp_pkg::P_DAT+k]};
                if (r_last)
                begin
                    nxt_lnk.rx_hold[k] = nxt_lnk.rx_sh[k];
                end
            end
            f_oe[asp_pkg::P_DAT+k] = cf.ch_en[k] & cf.ch_is_tx[k];
            f_o[asp_pkg::P_DAT+k] = nxt_lnk.tx_sh[k][WORD_W-1];
        end
        if (rx_rise & r_last)
        begin
            nxt_lnk.rx_tgl = ~lnk_ff.rx_tgl;
        end
        // flag moves per slot in network mode, else per frame
        flag_evt = tck_rise & t_last &
            (cf.net_mode | (lnk_ff.tslot == SLOT_LAST));
        if (cf.sync_mode_select & flag_evt)
        begin
            // output flag takes the control bit
            if (cf.rx_clock_direction_bit)
            begin
                nxt_lnk.of0_q = cf.output_flag_zero;
            end
            else if (fn[asp_pkg::P_RCK])
            begin
                nxt_lnk.if0_q = lnk_ff.pin_v[asp_pkg::P_RCK];
            end
        end
        // sync mode turns the receive clock pin into flag zero
        f_oe[asp_pkg::P_RCK] = cf.rx_clock_direction_bit;
        f_o[asp_pkg::P_RCK] = cf.sync_mode_select ? nxt_lnk.of0_q :
            nxt_lnk.gen_clk;
        f_oe[asp_pkg::P_TCK] = cf.tx_clock_direction_bit;
        f_o[asp_pkg::P_TCK] = nxt_lnk.gen_clk;
        // per-pin choice of GPIO or serial function
        for (int i = 0; i < NP; i++)
        begin
            md = cf.pin_mode[2*i+:2];
            case (md)
                asp_pkg::M_OUT:
                begin
                    nxt_lnk.pin_oe[i] = 1'b1;
                    nxt_lnk.pin_o[i] = cf.gpio_out[i];
                end
                asp_pkg::M_FUNC:
                begin
                    nxt_lnk.pin_oe[i] = f_oe[i];
                    nxt_lnk.pin_o[i] = f_o[i] & f_oe[i];
                end
                default:
                begin
                    nxt_lnk.pin_oe[i] = 1'b0;
                    nxt_lnk.pin_o[i] = 1'b0;
                end
            endcase
        end
    end

    // Link state shares the bus reset.
    always_ff @(posedge link_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            lnk_ff <= '{cfg_s1: asp_pkg::CFG_RST, cfg_s2: asp_pkg::CFG_RST,
                default: '0};
        end
        else
        begin
            lnk_ff <= nxt_lnk;
        end
    end

    // Outputs come straight from flops.
    assign prdata = bus_ff.prdata;
    assign pready = bus_ff.pready;
    assign pslverr = bus_ff.pslverr;
    assign rx_bit_clock_pin_o = lnk_ff.pin_o[asp_pkg::P_RCK];
    assign rx_bit_clock_pin_oe = lnk_ff.pin_oe[asp_pkg::P_RCK];
    assign tx_bit_clock_pin_o = lnk_ff.pin_o[asp_pkg::P_TCK];
    assign tx_bit_clock_pin_oe = lnk_ff.pin_oe[asp_pkg::P_TCK];
    assign data_pin_o = lnk_ff.pin_o[NP-1:asp_pkg::P_DAT];
    assign data_pin_oe = lnk_ff.pin_oe[NP-1:asp_pkg::P_DAT];
endmodule
`default_nettype wire

/* sim/asp_pin_checker_assertions.sv */
// Purpose: Concurrent checks on the APB side, the pin enables and the GPIO output levels.
// Assumes: Bound to asp_pin_port; register layout from asp_pkg.
// Notes: Shadows writes to know pin roles.
`timescale 1ns/10ps
`default_nettype none
module asp_pin_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [asp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic link_clk,
    input wire logic rx_bit_clock_pin_o,
    input wire logic rx_bit_clock_pin_oe,
    input wire logic tx_bit_clock_pin_o,
    input wire logic tx_bit_clock_pin_oe,
    input wire logic [2:0] data_pin_o,
    input wire logic [2:0] data_pin_oe
);
    logic [31:0] ctl, ckc, mode, gpo;
    logic [7:0] quiet;
    logic [1:0] lk;
    logic [4:0] fm, om, oe_v, o_v;
    logic [2:0] dfm, ch_tx, ch_en;
    logic wr_ok, ok_a;
    assign wr_ok = psel && penable && pwrite && pready;
    assign ok_a = paddr[1:0] == 2'h0 && paddr <= 8'h2C;
    assign oe_v = {data_pin_oe, tx_bit_clock_pin_oe, rx_bit_clock_pin_oe};
    assign o_v = {data_pin_o, tx_bit_clock_pin_o, rx_bit_clock_pin_o};
    assign dfm = fm[4:2];
    assign ch_tx = ctl[asp_pkg::B_DIR+:3];
    assign ch_en = ctl[asp_pkg::B_EN+:3];
    // Shadowed writes and cycles since the last write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl <= '0;
            ckc <= '0;
            mode <= '0;
            gpo <= '0;
            quiet <= 8'h0;
        end
        else
        begin
            quiet <= wr_ok ? 8'h0 : quiet + {7'h0, quiet != 8'hFF};
            if (wr_ok && paddr == asp_pkg::A_CTRL)
                ctl <= pwdata;
            if (wr_ok && paddr == asp_pkg::A_RCCR)
                ckc <= pwdata;
            if (wr_ok && paddr == asp_pkg::A_MODE)
                mode <= pwdata;
            if (wr_ok && paddr == asp_pkg::A_GPO)
                gpo <= pwdata;
        end
    end
    // Saturating link cycle count.
    always_ff @(posedge link_clk or negedge presetn)
    begin
        if (!presetn)
            lk <= 2'h0;
        else if (lk != 2'h3)
            lk <= lk + 2'h1;
    end
    // Pins in serial role and pins set as GPIO outputs.
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            fm[i] = mode[2*i+:2] == asp_pkg::M_FUNC;
            om[i] = mode[2*i+:2] == asp_pkg::M_OUT;
        end
    end
    a_ready_access: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pready) else $error("No ready in access cycle");
    a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> psel && penable && $past(psel && !penable))
        else $error("Stray ready");
    a_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !ok_a |-> pslverr && prdata == 32'h0)
        else $error("Unmapped access not refused");
    a_reset_off: assert property (@(posedge link_clk)
        disable iff (!presetn) lk < 2'h2 |-> oe_v == 5'h0)
        else $error("Pin driven after reset");
    a_gpio_oe: assert property (@(posedge pclk)
        disable iff (!presetn) quiet >= 8'h10 |-> (oe_v & ~fm) == (om & ~fm))
        else $error("GPIO pin enable wrong");
    a_gpio_out: assert property (@(posedge pclk)
        disable iff (!presetn) quiet >= 8'h10 |->
        (o_v & om) == (gpo[4:0] & om))
        else $error("GPIO output level wrong");
    a_flag_dir: assert property (@(posedge pclk)
        disable iff (!presetn) quiet >= 8'h10 && fm[0] |->
        rx_bit_clock_pin_oe == ckc[asp_pkg::B_RX_CLOCK_DIRECTION_BIT])
        else $error("Flag pin direction wrong");
    a_rx_release: assert property (@(posedge pclk)
        disable iff (!presetn) quiet >= 8'h10 |->
        (data_pin_oe & dfm & ~ch_tx) == 3'h0) else $error("Receiver pin driven");
    a_tx_drive: assert property (@(posedge pclk)
        disable iff (!presetn) quiet >= 8'h10 |->
        (data_pin_oe & dfm & ch_tx & ch_en) == (dfm & ch_tx & ch_en))
        else $error("Tx pin not driven");
endmodule
bind asp_pin_port asp_pin_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .rx_bit_clock_pin_o(rx_bit_clock_pin_o),
    .rx_bit_clock_pin_oe(rx_bit_clock_pin_oe),
    .tx_bit_clock_pin_o(tx_bit_clock_pin_o),
    .tx_bit_clock_pin_oe(tx_bit_clock_pin_oe),
    .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe));
`default_nettype wire

/* sim/asp_codec_model.sv */
// Purpose: Behavioural external codec on the five port pins.
// Assumes: Bit clock half period of eight link cycles.
// Notes: Clocks idle unless run; idle pins show park.
`timescale 1ns/10ps
`default_nettype none
module asp_codec_model #(
    parameter int W = 24
) (
    input wire logic link_clk,
    input wire logic presetn,
    input wire logic run_r,
    input wire logic run_t,
    input wire logic [4:0] park,
    input wire logic [2:0][W-1:0] rx_w,
    input wire logic [2:0][W-1:0] tx_w,
    input wire logic [4:0] o_v,
    input wire logic [4:0] oe_v,
    output logic [4:0] lvl,
    output logic [2:0] seen
);
    logic [3:0] cnt;
    logic [7:0] bi;
    logic [2:0][W-1:0] hist;
    logic [4:0] drv;
    logic run;
    assign run = run_r || run_t;
    // Codec clocks and MSB-first data; device drive wins.
    always_comb
    begin
        drv = park;
        if (run_r)
            drv[0] = cnt[3];
        if (run_t)
            drv[1] = cnt[3];
        for (int k = 0; k < 3; k++)
            if (run)
                drv[k+2] = rx_w[k][W-1-bi];
        for (int i = 0; i < 5; i++)
            lvl[i] = oe_v[i] ? o_v[i] : drv[i];
    end
    // Data steps at the falling edge; device bits are taken mid-low.
    always_ff @(posedge link_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            bi <= 8'h0;
            hist <= '0;
            seen <= 3'h0;
        end
        else if (run)
        begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'hF)
                bi <= (bi == W - 1) ? 8'h0 : bi + 8'h1;
            for (int k = 0; k < 3; k++)
            begin
                if (cnt == 4'h3)
                    hist[k] <= {hist[k][W-2:0], lvl[k+2]};
                if (hist[k] == tx_w[k])
                    seen[k] <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/tb.sv */
// Purpose: Self-checking bench for the audio serial port pin block.
// Assumes: Default parameters; codec model on the far side.
// Notes: Random GPIO rounds, then async, sync and flag scenarios.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, link_clk, pready, pslverr;
    logic [asp_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic rer, rck_o, rck_oe, tck_o, tck_oe, run_r, run_t;
    logic [2:0] dat_o, dat_oe, seen;
    logic [4:0] park, lvl, o_v, oe_v;
    logic [2:0][23:0] rxw, txw;
    logic [9:0] m;
    int failures, total_checks, cyc;
    assign o_v = {dat_o, tck_o, rck_o};
    assign oe_v = {dat_oe, tck_oe, rck_oe};
    asp_pin_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clk(link_clk), .rx_bit_clock_pin_i(lvl[0]),
        .rx_bit_clock_pin_o(rck_o), .rx_bit_clock_pin_oe(rck_oe),
        .tx_bit_clock_pin_i(lvl[1]), .tx_bit_clock_pin_o(tck_o),
        .tx_bit_clock_pin_oe(tck_oe), .data_pin_i(lvl[4:2]),
        .data_pin_o(dat_o), .data_pin_oe(dat_oe));
    asp_codec_model codec (.link_clk(link_clk), .presetn(presetn),
        .run_r(run_r), .run_t(run_t), .park(park), .rx_w(rxw), .tx_w(txw),
        .o_v(o_v), .oe_v(oe_v), .lvl(lvl), .seen(seen));
    // 40 MHz bus clock, 15 ns link clock.
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    // Pins with the given mode code.
    function automatic logic [4:0] sel(logic [9:0] md, logic [1:0] c);
        for (int i = 0; i < 5; i++)
            sel[i] = md[2*i+:2] == c;
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One APB transfer, bounded wait.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
            failures++;
        rdv = prdata;
        rer = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task rst;
        presetn <= 1'b0;
        run_r <= 1'b0;
        run_t <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    // New words, control, directions, serial modes.
    task cfg(input logic [31:0] c, input logic [31:0] k);
        txw[0] = 24'($urandom);
        rxw[1] = 24'($urandom);
        rxw[2] = 24'($urandom);
        apb(1'b1, asp_pkg::A_TX0, {8'h0, txw[0]});
        apb(1'b1, asp_pkg::A_CTRL, c);
        apb(1'b1, asp_pkg::A_RCCR, k);
        apb(1'b1, asp_pkg::A_MODE, 32'h3FF);
        repeat (8) @(posedge pclk);
    endtask
    task end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Cycle ceiling against a hang.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 9000)
        begin
            failures++;
            end_sim;
        end
    end
    // Main sequence.
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, run_r, run_t} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        park = 5'h0;
        rxw = '0;
        txw = '0;
        void'($urandom(32'h1CFD));
        rst;
        chk(32'(oe_v), 32'h0);
        rd(asp_pkg::A_MODE, 32'h0);
        rd(8'h30, 32'h0);
        chk(32'(rer), 32'h1);
        $display("reset test done");
        repeat (6)
        begin
            for (int i = 0; i < 5; i++)
                m[2*i+:2] = 2'($urandom_range(2));
            park <= 5'($urandom);
            apb(1'b1, asp_pkg::A_MODE, {22'h0, m});
            apb(1'b1, asp_pkg::A_GPO, $urandom);
            repeat (12) @(posedge pclk);
            chk(32'(oe_v), 32'(sel(m, asp_pkg::M_OUT)));
            chk(32'(o_v & sel(m, 2'h2)), 32'(pwdata[4:0] & sel(m, 2'h2)));
            rd(asp_pkg::A_GPI, 32'(park & sel(m, asp_pkg::M_IN)));
        end
        $display("gpio test done");
        rst;
        park <= 5'h0;
        cfg(32'h1C8, 32'h0);
        run_r <= 1'b1;
        repeat (1000) @(posedge pclk);
        rd(asp_pkg::A_RX0 + 8'h4, 32'(rxw[1]));
        rd(asp_pkg::A_RX0 + 8'h8, 32'(rxw[2]));
        rd(asp_pkg::A_RX0, 32'h0);
        chk(32'(dat_oe), 32'h1);
        chk(32'(seen[0]), 32'h0);
        $display("async test done");
        rst;
        park <= 5'h1;
        cfg(32'h1C9, 32'h0);
        run_t <= 1'b1;
        repeat (1000) @(posedge pclk);
        rd(asp_pkg::A_RX0 + 8'h4, 32'(rxw[1]));
        rd(asp_pkg::A_RX0 + 8'h8, 32'(rxw[2]));
        chk(32'(seen[0]), 32'h1);
        rd(asp_pkg::A_STAT, 32'h1);
        chk(32'(rck_oe), 32'h0);
        $display("sync test done");
        apb(1'b1, asp_pkg::A_RCCR, 32'h1);
        apb(1'b1, asp_pkg::A_CTRL, 32'h1CD);
        repeat (1000) @(posedge pclk);
        chk({30'h0, rck_oe, rck_o}, 32'h3);
        apb(1'b1, asp_pkg::A_CTRL, 32'h1C9);
        repeat (4) @(posedge pclk);
        chk(32'(rck_o), 32'h1);
        repeat (1000) @(posedge pclk);
        chk(32'(rck_o), 32'h0);
        $display("flag test done");
        end_sim;
    end
endmodule
`default_nettype wire
